// ---- verilog/audio_pwm_reset_sequencer.sv ----
// audio_pwm_reset_sequencer: start-up, power-down, fault recovery and mute ramp
// assumes all inputs are synchronous to clk_i; rst_i is the hardware reset pin
`timescale 1ns/1ps
module audio_pwm_reset_sequencer #(
   parameter int CTRL_READY_CYCLES = seq_pkg::CTRL_READY_CYC,
   parameter int MS_CYCLES = seq_pkg::MS_CYC,
   parameter int RATE_LOCK_EDGES = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // system controller pins
   input wire logic power_down_request_i,
   input wire logic mute_i,
   input wire logic power_stage_fault_in_i,
   // audio frame clock sampled for rate detection
   input wire logic lrclk_i,
   // control port side
   input wire logic vol_cmd_i,
   input wire logic [7:0] vol_level_i,
   input wire logic [3:0] recover_ms_i,
   input wire logic [7:0] slew_step_cyc_i,
   // status and outputs
   output logic ctrl_ready_o,
   output logic rate_valid_o,
   output logic [15:0] frame_period_o,
   output logic hold_state_n_o,
   output logic pwm_enable_o,
   output logic [7:0] volume_o
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   seq_pkg::seq_state_e state_reg;
   logic [31:0] ctr_reg;
   logic [3:0] rec_ms_reg;
   logic [31:0] rec_cyc;
   logic [15:0] per_cnt_reg;
   logic [15:0] per_last_reg;
   logic [3:0] lock_reg;
   logic lr_q_reg;
   logic lr_rise;
   logic [7:0] target_reg;
   logic [7:0] vol_reg;
   logic [7:0] slew_reg;
   logic [7:0] mute_tgt;
   logic quiet;
   logic fault_seen;
   logic [7:0] fault_cnt_reg;

   assign lr_rise = lrclk_i & ~lr_q_reg;
   assign quiet = rst_i | power_down_request_i;
   assign rec_cyc = 32'(rec_ms_reg) * 32'(MS_CYCLES);
   // fault must stand long enough to be trusted
   assign fault_seen = power_stage_fault_in_i && (fault_cnt_reg >= 8'(seq_pkg::FAULT_MIN_CYC - 1));

   // ----------------------------------------
   // fault pulse width filter
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !power_stage_fault_in_i) begin
         fault_cnt_reg <= 8'h00;
      end else if (!fault_seen) begin
         fault_cnt_reg <= fault_cnt_reg + 8'h01;
      end
   end

   // ----------------------------------------
   // rate detection from frame clock
   // ----------------------------------------
   // period measured in master clocks; locks after several equal periods
   always_ff @(posedge clk_i) begin
      if (quiet) begin
         lr_q_reg <= 1'b0;
         per_cnt_reg <= 16'h0000;
         per_last_reg <= 16'h0000;
         lock_reg <= 4'h0;
      end else begin
         lr_q_reg <= lrclk_i;
         if (lr_rise) begin
            per_cnt_reg <= 16'h0001;
            per_last_reg <= per_cnt_reg;
            if (per_cnt_reg == per_last_reg && per_cnt_reg != 16'h0000) begin
               if (lock_reg != 4'(RATE_LOCK_EDGES)) begin
                  lock_reg <= lock_reg + 4'h1;
               end
            end else begin
               lock_reg <= 4'h0; // period changed: relock
            end
         end else if (per_cnt_reg != 16'hffff) begin
            per_cnt_reg <= per_cnt_reg + 16'h0001;
         end
      end
   end
   assign rate_valid_o = (lock_reg == 4'(RATE_LOCK_EDGES));
   assign frame_period_o = per_last_reg;

   // ----------------------------------------
   // start-up and recovery sequencer
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (quiet) begin
         state_reg <= seq_pkg::ST_HOLD;
         ctr_reg <= 32'h0;
      end else begin
         case (state_reg)
            seq_pkg::ST_HOLD: begin
               state_reg <= seq_pkg::ST_WAIT_CTRL;
               ctr_reg <= 32'h0;
            end
            seq_pkg::ST_WAIT_CTRL: begin
               if (ctr_reg >= 32'(CTRL_READY_CYCLES - 1)) begin
                  state_reg <= seq_pkg::ST_WAIT_RATE;
               end else begin
                  ctr_reg <= ctr_reg + 32'h1;
               end
            end
            seq_pkg::ST_WAIT_RATE: begin
               if (rate_valid_o) begin
                  state_reg <= seq_pkg::ST_WAIT_VOL;
               end
            end
            seq_pkg::ST_WAIT_VOL: begin
               if (!rate_valid_o) begin
                  state_reg <= seq_pkg::ST_WAIT_RATE;
               end else if (vol_cmd_i) begin
                  state_reg <= seq_pkg::ST_RUN;
               end
            end
            seq_pkg::ST_RUN: begin
               if (fault_seen) begin
                  state_reg <= seq_pkg::ST_RECOVER;
                  ctr_reg <= 32'h0;
               end
            end
            seq_pkg::ST_RECOVER: begin
               if (fault_seen) begin
                  ctr_reg <= 32'h0; // fault still present: restart interval
               end else if (ctr_reg >= rec_cyc - 32'h1) begin
                  state_reg <= seq_pkg::ST_RUN;
               end else begin
                  ctr_reg <= ctr_reg + 32'h1;
               end
            end
            default: state_reg <= seq_pkg::ST_HOLD;
         endcase
      end
   end

   // ----------------------------------------
   // recovery interval, clamped to 1..10 ms
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rec_ms_reg <= seq_pkg::RECOVER_MS_RST;
      end else if (recover_ms_i < 4'(seq_pkg::RECOVER_MIN_MS)) begin
         rec_ms_reg <= 4'(seq_pkg::RECOVER_MIN_MS);
      end else if (recover_ms_i > 4'(seq_pkg::RECOVER_MAX_MS)) begin
         rec_ms_reg <= 4'(seq_pkg::RECOVER_MAX_MS);
      end else begin
         rec_ms_reg <= recover_ms_i;
      end
   end

   // ----------------------------------------
   // outputs driven from state
   // ----------------------------------------
   // hold is combinational on quiet so it falls within one cycle
   assign hold_state_n_o = !quiet && (state_reg == seq_pkg::ST_RUN);
   assign pwm_enable_o = hold_state_n_o;
   assign ctrl_ready_o = !quiet && (state_reg != seq_pkg::ST_HOLD) && (state_reg != seq_pkg::ST_WAIT_CTRL);

   // ----------------------------------------
   // volume ramp toward master volume or mute
   // ----------------------------------------
   // one step per slew_step_cyc_i+1 clocks; never jumps
   assign mute_tgt = mute_i ? 8'h00 : target_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         target_reg <= seq_pkg::VOLUME_RST;
         vol_reg <= seq_pkg::VOLUME_RST;
         slew_reg <= 8'h00;
      end else begin
         if (vol_cmd_i) begin
            target_reg <= vol_level_i;
         end
         if (vol_reg == mute_tgt || slew_reg < slew_step_cyc_i) begin
            slew_reg <= (vol_reg == mute_tgt) ? 8'h00 : slew_reg + 8'h01;
         end else begin
            slew_reg <= 8'h00;
            vol_reg <= (vol_reg < mute_tgt) ? vol_reg + 8'h01 : vol_reg - 8'h01;
         end
      end
   end
   assign volume_o = vol_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_hold_quiet_low: assert property (@(posedge clk_i) quiet |-> !hold_state_n_o)
      else $error("hold high during reset or power-down");
   chk_pdn_hold_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(power_down_request_i) |-> !hold_state_n_o [*3])
      else $error("hold not low after power-down");
   chk_run_needs_vol: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == seq_pkg::ST_WAIT_VOL) && !vol_cmd_i |=> state_reg != seq_pkg::ST_RUN)
      else $error("run without volume command");
   chk_vol_one_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (vol_reg - $past(vol_reg) == 8'h01) || ($past(vol_reg) - vol_reg == 8'h01) ||
      (vol_reg == $past(vol_reg)))
      else $error("volume stepped by more than one");
   chk_fault_stops_pwm: assert property (@(posedge clk_i) disable iff (quiet)
      (state_reg == seq_pkg::ST_RUN) && fault_seen |=> !pwm_enable_o [*2])
      else $error("pwm kept after fault");
   chk_fault_filter: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(power_stage_fault_in_i) |-> !fault_seen)
      else $error("fault taken too early");
   chk_ctrl_wait: assert property (@(posedge clk_i) disable iff (quiet)
      (state_reg == seq_pkg::ST_WAIT_CTRL) |-> !ctrl_ready_o)
      else $error("control ready too early");
   chk_run_rate_lock: assert property (@(posedge clk_i) disable iff (quiet)
      $rose(state_reg == seq_pkg::ST_RUN) && $past(state_reg) == seq_pkg::ST_WAIT_VOL
      |-> $past(rate_valid_o))
      else $error("run without rate lock");
   cov_run: cover property (@(posedge clk_i) $rose(hold_state_n_o));
   cov_recover: cover property (@(posedge clk_i) state_reg == seq_pkg::ST_RECOVER ##1 state_reg == seq_pkg::ST_RUN);
   cov_mute: cover property (@(posedge clk_i) mute_i && vol_reg == 8'h00);
endmodule

// ---- verilog/seq_pkg.sv ----
// package: constants for the audio pwm reset and power sequencer
// assumes a 100 MHz master clock; all times except the recovery limits in ms are converted to cycles here
package seq_pkg;
   // ----------------------------------------
   // clock
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   // ----------------------------------------
   // timing figures in their own units
   // ----------------------------------------
   localparam int RESET_MIN_NS = 400;
   localparam int FAULT_MIN_NS = 350;
   localparam int CTRL_READY_MS = 3;
   localparam int HOLD_LOW_MAX_NS = 370;
   localparam int RECOVER_MIN_MS = 1;
   localparam int RECOVER_MAX_MS = 10;
   localparam int PDN_PRE_CLKS = 5;
   // ----------------------------------------
   // derived cycle counts (least times round up)
   // ----------------------------------------
   localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int FAULT_MIN_CYC = (FAULT_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_LOW_MAX_CYC = (HOLD_LOW_MAX_NS * CLK_MHZ) / 1000;
   localparam int CTRL_READY_CYC = CTRL_READY_MS * 1000 * CLK_MHZ;
   localparam int MS_CYC = 1000 * CLK_MHZ;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [3:0] RECOVER_MS_RST = 4'h1;
   localparam logic [7:0] VOLUME_RST = 8'h00;
   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_HOLD,
      ST_WAIT_CTRL,
      ST_WAIT_RATE,
      ST_WAIT_VOL,
      ST_RUN,
      ST_RECOVER
   } seq_state_e;
endpackage

// ---- dv/ctrl_stage_model.sv ----
// partner model: frame clock source and power stage fault pulser
// assumes clk_i is the master clock of the sequencer
`timescale 1ns/1ps
module ctrl_stage_model #(
   parameter int HALF_CYC = 8
) (
   // clock
   input wire logic clk_i,
   // bench commands
   input wire logic frames_on_i,
   input wire logic fault_req_i,
   // pins toward the sequencer
   output logic lrclk_o,
   output logic fault_o
);
   int half_cnt = 0;
   int fault_cnt = 0;
   // frame clock, parked low when stopped so no stale edges
   always_ff @(posedge clk_i) begin
      if (!frames_on_i) begin
         lrclk_o <= 1'b0;
         half_cnt <= 0;
      end else if (half_cnt == HALF_CYC - 1) begin
         lrclk_o <= ~lrclk_o;
         half_cnt <= 0;
      end else begin
         half_cnt <= half_cnt + 1;
      end
   end
   // fault held one cycle past the least width
   always_ff @(posedge clk_i) begin
      if (fault_req_i) begin
         fault_cnt <= seq_pkg::FAULT_MIN_CYC + 1;
      end else if (fault_cnt != 0) begin
         fault_cnt <= fault_cnt - 1;
      end
   end
   assign fault_o = (fault_cnt != 0);
endmodule

// ---- dv/test_audio_pwm_reset_sequencer.sv ----
// testbench: start-up, lock, mute ramp, fault recovery, power-down, reset
// assumes a short ready delay and millisecond via parameters
`timescale 1ns/1ps
module test_audio_pwm_reset_sequencer;
   // -----------------------------
   // signals
   // -----------------------------
   localparam int MS_C = 10;
   localparam int READY_C = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic power_down_request_i = 1'b0;
   logic mute_i = 1'b0;
   logic vol_cmd_i = 1'b0;
   logic [7:0] vol_level_i = 8'h04;
   logic [3:0] recover_ms_i = 4'h2;
   logic [7:0] slew_step_cyc_i = 8'h01;
   logic frames_on = 1'b0;
   logic fault_req = 1'b0;
   logic lrclk, fault, ctrl_ready_o, rate_valid_o, hold_state_n_o, pwm_enable_o;
   logic [15:0] frame_period_o;
   logic [7:0] volume_o;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   always #5 clk_i = ~clk_i;
   ctrl_stage_model peer (.clk_i(clk_i), .frames_on_i(frames_on), .fault_req_i(fault_req),
      .lrclk_o(lrclk), .fault_o(fault));
   audio_pwm_reset_sequencer #(.CTRL_READY_CYCLES(READY_C), .MS_CYCLES(MS_C), .RATE_LOCK_EDGES(4)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .power_down_request_i(power_down_request_i), .mute_i(mute_i),
      .power_stage_fault_in_i(fault), .lrclk_i(lrclk), .vol_cmd_i(vol_cmd_i), .vol_level_i(vol_level_i),
      .recover_ms_i(recover_ms_i), .slew_step_cyc_i(slew_step_cyc_i), .ctrl_ready_o(ctrl_ready_o),
      .rate_valid_o(rate_valid_o), .frame_period_o(frame_period_o), .hold_state_n_o(hold_state_n_o),
      .pwm_enable_o(pwm_enable_o), .volume_o(volume_o));
   // -----------------------------
   // helpers
   // -----------------------------
   task automatic test_done;
      if (fails == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp_bit(string what, logic exp, logic got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cmp_vec(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait; outputs sampled 1 ns after the edge so updates have landed
   task automatic wait_bit(ref logic sig, input logic val, input int limit, output int n);
      n = 0;
      while (sig !== val && n < limit) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask
   task automatic vol_pulse;
      @(posedge clk_i);
      vol_cmd_i <= 1'b1;
      @(posedge clk_i);
      vol_cmd_i <= 1'b0;
      #1;
   endtask
   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic wait_ready;
      int n;
      @(posedge clk_i);
      #1;
      cmp_bit("early ready", 1'b0, ctrl_ready_o);
      cmp_bit("start-up hold", 1'b0, hold_state_n_o);
      wait_bit(ctrl_ready_o, 1'b1, READY_C + 4, n);
      cmp_bit("ctrl ready", 1'b1, ctrl_ready_o);
      cmp_bit("ready delay", 1'b1, n >= READY_C - 2);
      cmp_bit("hold before vol", 1'b0, hold_state_n_o);
   endtask
   task automatic run_up;
      int n;
      wait_bit(rate_valid_o, 1'b1, 200, n);
      cmp_bit("rate lock", 1'b1, rate_valid_o);
      cmp_vec("frame period", 16'h0010, frame_period_o);
      cmp_bit("no vol no audio", 1'b0, hold_state_n_o);
      vol_pulse();
      cmp_bit("hold after vol", 1'b1, hold_state_n_o);
      cmp_bit("pwm enable", 1'b1, pwm_enable_o);
   endtask
   task automatic early_vol;
      vol_pulse();
      @(posedge clk_i);
      frames_on <= 1'b1;
      #1;
      cmp_bit("vol before lock", 1'b0, hold_state_n_o);
      run_up();
   endtask
   task automatic mute_ramp;
      int n = 0;
      repeat (20) @(posedge clk_i);
      #1;
      cmp_vec("volume up", 16'h0004, {8'h00, volume_o});
      @(posedge clk_i);
      mute_i <= 1'b1;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (volume_o !== 8'h00 && n < 100);
      cmp_vec("muted volume", 16'h0000, {8'h00, volume_o});
      cmp_bit("gradual ramp", 1'b1, n >= 6);
      @(posedge clk_i);
      mute_i <= 1'b0;
      n = 0;
      // release must climb back one step at a time, not jump
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (volume_o !== 8'h04 && n < 100);
      cmp_vec("unmuted volume", 16'h0004, {8'h00, volume_o});
      cmp_bit("gradual rise", 1'b1, n >= 6);
   endtask
   // 4'hf is clamped to the 10 ms ceiling
   task automatic fault_recover(logic [3:0] ms, int exp_ms);
      int n;
      @(posedge clk_i);
      recover_ms_i <= ms;
      fault_req <= 1'b1;
      @(posedge clk_i);
      fault_req <= 1'b0;
      // the fault must stand its least width before the output drops
      wait_bit(hold_state_n_o, 1'b0, seq_pkg::FAULT_MIN_CYC + 4, n);
      cmp_bit("hold on fault", 1'b0, hold_state_n_o);
      cmp_bit("fault filter", 1'b1, n >= seq_pkg::FAULT_MIN_CYC);
      wait_bit(hold_state_n_o, 1'b1, 300, n);
      cmp_bit("recovered", 1'b1, hold_state_n_o);
      // interval within a quarter either way, plus the short tail of the fault pulse
      cmp_bit("recover span", 1'b1, n >= exp_ms * MS_C * 3 / 4 && n <= 4 + exp_ms * MS_C * 5 / 4);
   endtask
   task automatic power_down;
      int n;
      @(posedge clk_i);
      power_down_request_i <= 1'b1;
      wait_bit(hold_state_n_o, 1'b0, seq_pkg::HOLD_LOW_MAX_CYC, n);
      cmp_bit("hold on pdn", 1'b0, hold_state_n_o);
      repeat (seq_pkg::PDN_PRE_CLKS) @(posedge clk_i);
      power_down_request_i <= 1'b0;
      wait_ready();
      run_up();
   endtask
   task automatic reset_midrun;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (seq_pkg::RESET_MIN_CYC) @(posedge clk_i);
      #1;
      cmp_bit("hold in reset", 1'b0, hold_state_n_o);
      cmp_bit("ready in reset", 1'b0, ctrl_ready_o);
      @(posedge clk_i);
      rst_i <= 1'b0;
      wait_ready();
      run_up();
   endtask
   // -----------------------------
   // main sequence and hang guard
   // -----------------------------
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_ready();
      early_vol();
      mute_ramp();
      fault_recover(4'h2, 2);
      fault_recover(4'hf, 10);
      power_down();
      reset_midrun();
      test_done();
   end
endmodule
